// ### src/boot_remap_sram_bank_decoder.sv
`timescale 1ns/100ps
// Functional notes
// - After reset coupled areas empty; bus area holds blocks 4,3,2,1,0 upward.
// - Instruction area blocks 1 then 0, data area 3 then 2; rest fill.
// - 80 KB RAM answers every access in one clock cycle.
// - 16 KB RAM decoded at its fixed base, one cycle access.
// - Processor starts fetching at address zero from the selected boot memory.
// - Once software sets remap, bus-area RAM appears at address zero.
// - Without remap, boot pin level latched at the first edge after reset release picks address zero memory.
// - First megabyte reserved for the selected boot memory.
// - Boot pin high and no remap: ROM at address zero.
// - Boot pin low and no remap: external chip select zero at zero.
// - Other memories stay at their own bases whatever boot and remap say.
// - External boot runs slow clock with static controller default setup.
// - Each external chip select gets its own fixed 256 MB window.
// - Block 4 always belongs to the bus-accessible area.
// - After remap only processor masters see bus area at address zero.
// - Coupled area sizes only 0, 16 or 32 KB; remainder goes to bus.
module boot_remap_sram_bank_decoder
(
  input  wire logic                              clk_sys_in,
  input  wire logic                              rst_b_in,
  input  wire logic                              boot_mode_pin_in,
  input  wire logic                              remap_set_in,
  input  wire logic [1:0]                        icoupled_size_in,
  input  wire logic [1:0]                        dcoupled_size_in,
  input  wire logic                              req_valid_in,
  input  wire logic [31:0]                       req_addr_in,
  input  wire logic                              req_cpu_master_in,
  output logic                                   resp_valid_out,
  output logic                                   resp_error_out,
  output logic                                   sel_rom_out,
  output logic                                   sel_ram80_out,
  output logic                                   sel_ram16_out,
  output logic [mem_map_pkg::NUM_EXT_CS-1:0]     ext_cs_out,
  output logic [2:0]                             ram_block_out,
  output logic [27:0]                            mem_offset_out,
  output logic                                   remap_active_out,
  output logic                                   boot_from_rom_out,
  output logic                                   boot_slow_clock_out,
  output logic                                   static_byte_select_out,
  output logic                                   static_bus16_out,
  output logic                                   static_cs_strobes_out
);
  import mem_map_pkg::*;

  boot_state_t                 boot_state_reg;
  logic                        boot_rom_reg;
  logic                        remap_reg;
  logic [2:0]                  slot_blk [NUM_BLOCKS];
  logic [NUM_BLOCKS-1:0]       slot_used;
  logic                        err_next;
  logic                        rom_next;
  logic                        r80_next;
  logic                        r16_next;
  logic [NUM_EXT_CS-1:0]       cs_next;
  logic [2:0]                  blk_next;
  logic [27:0]                 ofs_next;
  logic [3:0]                  bank;
  logic [7:0]                  seg;
  logic [2:0]                  slot_idx;
  logic                        slot_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Boot pin is taken at the first edge after release, never in reset itself
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      boot_state_reg <= BS_LATCH;
      boot_rom_reg   <= BOOT_ROM_RST;
    end
    else
    begin
      case (boot_state_reg)
        BS_LATCH:
        begin
          boot_rom_reg   <= boot_mode_pin_in;
          boot_state_reg <= BS_RUN;
        end
        BS_RUN:
        begin
          boot_state_reg <= BS_RUN;
        end
        default:
        begin
          boot_state_reg <= BS_LATCH;
        end
      endcase
    end
  end

  // Remap is sticky; only a reset takes it back
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      remap_reg <= REMAP_RST;
    end
    else if (remap_set_in)
    begin
      remap_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One lookup per bus-area slot
  for (genvar s = 0; s < NUM_BLOCKS; s++)
  begin : g_slot
    slot_if sif ();
    assign sif.icoupled_sz = icoupled_size_in;
    assign sif.dcoupled_sz = dcoupled_size_in;
    assign slot_blk[s]     = sif.block_id;
    assign slot_used[s]    = sif.used;
    bus_slot_map #(.SLOT(s)) u_map (.port(sif.slot));
  end

  assign bank     = req_addr_in[31:28];
  assign seg      = req_addr_in[27:20];
  assign slot_idx = req_addr_in[16:14];
  // Slot field beyond 80 KB, or a slot left empty, is unmapped
  assign slot_ok  = (req_addr_in[19:17] == 3'h0) && (slot_idx < 3'(NUM_BLOCKS))
                    && slot_used[slot_idx];

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  always_comb
  begin
    err_next = 1'b0;
    rom_next = 1'b0;
    r80_next = 1'b0;
    r16_next = 1'b0;
    cs_next  = '0;
    blk_next = 3'h0;
    ofs_next = {14'h0, req_addr_in[BLK_OFS_W-1:0]};
    if (bank == BANK_INTERNAL)
    begin
      case (seg)
        SEG_BOOT:
        begin
          if (remap_reg && req_cpu_master_in)
          begin
            r80_next = slot_ok;
            err_next = !slot_ok;
            blk_next = slot_ok ? slot_blk[slot_idx] : 3'h0;
          end
          else if (boot_rom_reg)
          begin
            rom_next = 1'b1;
            ofs_next = {8'h0, req_addr_in[19:0]};
          end
          else
          begin
            cs_next[0] = 1'b1;
            ofs_next   = {8'h0, req_addr_in[19:0]};
          end
        end
        SEG_ICOUPLED:
        begin
          r80_next = (req_addr_in[19:15] == 5'h0) &&
                     (req_addr_in[14] ? (icoupled_size_in == SZ_32K)
                                      : (icoupled_size_in == SZ_16K ||
                                         icoupled_size_in == SZ_32K));
          err_next = !r80_next;
          blk_next = req_addr_in[14] ? 3'h0 : 3'h1;
        end
        SEG_DCOUPLED:
        begin
          r80_next = (req_addr_in[19:15] == 5'h0) &&
                     (req_addr_in[14] ? (dcoupled_size_in == SZ_32K)
                                      : (dcoupled_size_in == SZ_16K ||
                                         dcoupled_size_in == SZ_32K));
          err_next = !r80_next;
          blk_next = req_addr_in[14] ? 3'h2 : 3'h3;
        end
        SEG_BUS_AREA:
        begin
          r80_next = slot_ok;
          err_next = !slot_ok;
          blk_next = slot_ok ? slot_blk[slot_idx] : 3'h0;
        end
        SEG_ROM:
        begin
          rom_next = 1'b1;
          ofs_next = {8'h0, req_addr_in[19:0]};
        end
        SEG_SRAM16:
        begin
          r16_next = (req_addr_in[19:14] == 6'h0);
          err_next = !r16_next;
        end
        default:
        begin
          err_next = 1'b1;
        end
      endcase
    end
    else if (bank >= BANK_EXT_FIRST && bank <= BANK_EXT_LAST)
    begin
      // Whole 256 MB bank goes to one chip select
      cs_next  = NUM_EXT_CS'(9'h001 << (bank - BANK_EXT_FIRST));
      ofs_next = req_addr_in[27:0];
    end
    else
    begin
      err_next = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Answer one cycle after the request; selects last only that cycle
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      resp_valid_out <= 1'b0;
      resp_error_out <= 1'b0;
      sel_rom_out    <= 1'b0;
      sel_ram80_out  <= 1'b0;
      sel_ram16_out  <= 1'b0;
      ext_cs_out     <= '0;
      ram_block_out  <= 3'h0;
      mem_offset_out <= 28'h0;
    end
    else
    begin
      resp_valid_out <= req_valid_in;
      resp_error_out <= req_valid_in && err_next;
      sel_rom_out    <= req_valid_in && rom_next;
      sel_ram80_out  <= req_valid_in && r80_next;
      sel_ram16_out  <= req_valid_in && r16_next;
      ext_cs_out     <= req_valid_in ? cs_next : '0;
      ram_block_out  <= blk_next;
      mem_offset_out <= ofs_next;
    end
  end

  // Status and boot defaults; slow clock held until software remaps
  assign remap_active_out       = remap_reg;
  assign boot_from_rom_out      = boot_rom_reg;
  assign boot_slow_clock_out    = !remap_reg;
  assign static_byte_select_out = STATIC_BYTE_SELECT;
  assign static_bus16_out       = STATIC_BUS16;
  assign static_cs_strobes_out  = STATIC_CS_STROBES;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_reset_alloc;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (icoupled_size_in == SZ_0K && dcoupled_size_in == SZ_0K)
      |-> (slot_blk[4] == 3'h0 && slot_blk[1] == 3'h3 && slot_used[4]);
  endproperty
  a_reset_alloc: assert property (p_reset_alloc) else $error("reset allocation wrong");

  property p_icoupled_hi;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (req_valid_in && req_addr_in[31:14] == 18'h00041 && icoupled_size_in == SZ_32K)
      |=> (sel_ram80_out && ram_block_out == 3'h0);
  endproperty
  a_icoupled_hi: assert property (p_icoupled_hi) else $error("instruction slot 1 wrong");

  property p_one_cycle;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    req_valid_in |=> resp_valid_out ##1 (resp_valid_out == $past(req_valid_in));
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("answer not in one cycle");

  property p_sram16;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (req_valid_in && req_addr_in[31:14] == 18'h00140) |=> (sel_ram16_out && !resp_error_out);
  endproperty
  a_sram16: assert property (p_sram16) else $error("16 KB RAM not selected");

  property p_boot_rom;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (req_valid_in && req_addr_in[31:20] == 12'h000 && !remap_reg && boot_rom_reg)
      |=> (sel_rom_out && ext_cs_out == '0);
  endproperty
  a_boot_rom: assert property (p_boot_rom) else $error("ROM not at zero");

  property p_boot_ext;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (req_valid_in && req_addr_in[31:20] == 12'h000 && !remap_reg && !boot_rom_reg)
      |=> (ext_cs_out == 9'h001 && !sel_rom_out);
  endproperty
  a_boot_ext: assert property (p_boot_ext) else $error("chip select zero not at zero");

  property p_remap_other;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (req_valid_in && req_addr_in[31:20] == 12'h000 && remap_reg && !req_cpu_master_in)
      |=> !sel_ram80_out;
  endproperty
  a_remap_other: assert property (p_remap_other) else $error("non-cpu saw remap");

  property p_ext_window;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (req_valid_in && req_addr_in[31:28] == 4'h3) |=> (ext_cs_out == 9'h004);
  endproperty
  a_ext_window: assert property (p_ext_window) else $error("bank 3 not chip select 2");

  property p_remap_sticky;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    remap_active_out |=> remap_active_out [*3];
  endproperty
  a_remap_sticky: assert property (p_remap_sticky) else $error("remap dropped");

  property p_empty_slot;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (req_valid_in && req_addr_in[31:14] == 18'h000c1 && icoupled_size_in == SZ_32K &&
     dcoupled_size_in == SZ_32K) |=> resp_error_out;
  endproperty
  a_empty_slot: assert property (p_empty_slot) else $error("empty slot not refused");

  property p_block4_fixed;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (slot_blk[0] == FIXED_BLOCK) && slot_used[0];
  endproperty
  a_block4_fixed: assert property (p_block4_fixed) else $error("block 4 not in bus area");
endmodule

// ### src/bus_slot_map.sv
`timescale 1ns/100ps
module bus_slot_map
#(
  parameter int SLOT = 0
)
(
  slot_if.slot port
);
  import mem_map_pkg::*;

  logic [3:0] claimed;
  logic [2:0] cnt;

  // Blocks taken by the coupled areas; illegal size code claims nothing
  always_comb
  begin
    claimed[1] = (port.icoupled_sz == SZ_16K) || (port.icoupled_sz == SZ_32K);
    claimed[0] = (port.icoupled_sz == SZ_32K);
    claimed[3] = (port.dcoupled_sz == SZ_16K) || (port.dcoupled_sz == SZ_32K);
    claimed[2] = (port.dcoupled_sz == SZ_32K);
  end

  // Slot 0 is block 4, then free blocks in descending order
  always_comb
  begin
    cnt           = 3'h0;
    port.block_id = 3'h0;
    port.used     = 1'b0;
    if (SLOT == 0)
    begin
      port.block_id = FIXED_BLOCK;
      port.used     = 1'b1;
    end
    else
    begin
      for (int b = 3; b >= 0; b--)
      begin
        if (!claimed[b])
        begin
          cnt = cnt + 3'h1;
          if ((cnt == 3'(SLOT)) && !port.used)
          begin
            port.block_id = 3'(b);
            port.used     = 1'b1;
          end
        end
      end
    end
  end
endmodule

// ### src/mem_map_pkg.sv
package mem_map_pkg;

  // Top nibble of the address picks one 256 Mbyte bank
  localparam logic [3:0] BANK_INTERNAL = 4'h0;
  localparam logic [3:0] BANK_EXT_FIRST = 4'h1;
  localparam logic [3:0] BANK_EXT_LAST  = 4'h9;

  // Second level: 1 Mbyte segments inside the internal bank
  localparam logic [7:0] SEG_BOOT      = 8'h00;
  localparam logic [7:0] SEG_ICOUPLED  = 8'h01;
  localparam logic [7:0] SEG_DCOUPLED  = 8'h02;
  localparam logic [7:0] SEG_BUS_AREA  = 8'h03;
  localparam logic [7:0] SEG_ROM       = 8'h04;
  localparam logic [7:0] SEG_SRAM16    = 8'h05;

  // 16 Kbyte blocks: offset width and slot field position
  localparam int         BLK_OFS_W     = 14;
  localparam int         NUM_BLOCKS    = 5;
  localparam int         NUM_EXT_CS    = 9;
  localparam logic [2:0] FIXED_BLOCK   = 3'h4;

  // Coupled area sizes, code 3 is not a legal size
  localparam logic [1:0] SZ_0K         = 2'h0;
  localparam logic [1:0] SZ_16K        = 2'h1;
  localparam logic [1:0] SZ_32K        = 2'h2;

  // Reset values
  localparam logic       REMAP_RST     = 1'b0;
  localparam logic       BOOT_ROM_RST  = 1'b0;

  // Static controller boot defaults
  localparam logic       STATIC_BYTE_SELECT = 1'b1;
  localparam logic       STATIC_BUS16       = 1'b1;
  localparam logic       STATIC_CS_STROBES  = 1'b1;

  // Access latency in master clock cycles
  localparam int         ACCESS_CYCLES = 1;

  typedef enum logic [1:0]
  {
    BS_LATCH = 2'h1,
    BS_RUN   = 2'h2
  } boot_state_t;

endpackage

// ### src/slot_if.sv
`timescale 1ns/100ps
interface slot_if;
  logic [1:0] icoupled_sz;
  logic [1:0] dcoupled_sz;
  logic [2:0] block_id;
  logic       used;

  modport master (output icoupled_sz, output dcoupled_sz, input block_id, input used);
  modport slot   (input icoupled_sz, input dcoupled_sz, output block_id, output used);
endinterface

// ### test/bus_master_model.sv
`timescale 1ns/100ps
// Requester standing in for the bus masters and boot software
module bus_master_model
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_b_in,
  input  wire logic        go_in,
  input  wire logic        go_cpu_in,
  input  wire logic        remap_go_in,
  input  wire logic [31:0] go_addr_in,
  output logic             req_valid_out,
  output logic             req_cpu_master_out,
  output logic             remap_set_out,
  output logic [31:0]      req_addr_out
);
  // Idle lines toggle so a stale address never looks usable
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      req_valid_out      <= 1'b0;
      req_cpu_master_out <= 1'b0;
      remap_set_out      <= 1'b0;
      req_addr_out       <= 32'h0;
    end
    else
    begin
      req_valid_out      <= go_in;
      remap_set_out      <= remap_go_in;
      req_addr_out       <= go_in ? go_addr_in : ~req_addr_out;
      req_cpu_master_out <= go_in ? go_cpu_in : ~req_cpu_master_out;
    end
  end
endmodule

// ### test/test_boot_remap_sram_bank_decoder.sv
`timescale 1ns/100ps
// Self-checking bench for the boot remap and bank decoder
module test_boot_remap_sram_bank_decoder;
  import mem_map_pkg::*;
  logic                  clk_sys_in = 1'b0;
  logic                  rst_b_in = 1'b0;
  logic                  boot_mode_pin_in = 1'b1;
  logic [1:0]            icoupled_size_in = 2'h0;
  logic [1:0]            dcoupled_size_in = 2'h0;
  logic                  go = 1'b0, go_cpu = 1'b0, remap_go = 1'b0;
  logic [31:0]           go_addr = 32'h0, rnd = 32'h3;
  logic                  req_valid_in, req_cpu_master_in, remap_set_in;
  logic [31:0]           req_addr_in;
  logic                  resp_valid_out, resp_error_out, sel_rom_out;
  logic                  sel_ram80_out, sel_ram16_out;
  logic [NUM_EXT_CS-1:0] ext_cs_out;
  logic [2:0]            ram_block_out;
  logic [27:0]           mem_offset_out;
  logic                  remap_active_out, boot_from_rom_out, boot_slow_clock_out;
  logic                  static_byte_select_out, static_bus16_out, static_cs_strobes_out;
  logic                  mdl_remap = 1'b0, mdl_boot = 1'b0, latched = 1'b0, pend = 1'b0;
  logic [44:0]           expq [$];
  logic [31:0]           bases [18] = '{32'h00100000, 32'h00104000, 32'h00108000,
    32'h00200000, 32'h00204000, 32'h00208000, 32'h00300000, 32'h00304000, 32'h00308000,
    32'h0030c000, 32'h00310000, 32'h00314000, 32'h00000000, 32'h00010000, 32'h00014000,
    32'h00400000, 32'h00500000, 32'h00504000};
  int                    fails = 0, compares = 0, cycles = 0;

  // 10 MHz master clock
  always #50 clk_sys_in = ~clk_sys_in;

  bus_master_model master_u (.clk_sys_in, .rst_b_in, .go_in(go), .go_cpu_in(go_cpu),
    .remap_go_in(remap_go), .go_addr_in(go_addr), .req_valid_out(req_valid_in),
    .req_cpu_master_out(req_cpu_master_in), .remap_set_out(remap_set_in),
    .req_addr_out(req_addr_in));

  boot_remap_sram_bank_decoder dut_u (.clk_sys_in, .rst_b_in, .boot_mode_pin_in,
    .remap_set_in, .icoupled_size_in, .dcoupled_size_in, .req_valid_in, .req_addr_in,
    .req_cpu_master_in, .resp_valid_out, .resp_error_out, .sel_rom_out, .sel_ram80_out,
    .sel_ram16_out, .ext_cs_out, .ram_block_out, .mem_offset_out, .remap_active_out,
    .boot_from_rom_out, .boot_slow_clock_out, .static_byte_select_out, .static_bus16_out,
    .static_cs_strobes_out);

  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Reference decode; unclaimed blocks fill the bus area after block 4
  function automatic logic [44:0] expect_resp(input logic [31:0] a, input logic cpu,
    input logic [1:0] isz, input logic [1:0] dsz, input logic rmp, input logic boot);
    logic [2:0]  lst [5];
    logic [3:0]  cl;
    logic [8:0]  ext;
    logic [27:0] off;
    logic [5:0]  slot;
    logic [2:0]  blk;
    logic        rom, r80, r16, bus, err;
    int          n;
    cl = {dsz == 2'h1 || dsz == 2'h2, dsz == 2'h2, isz == 2'h1 || isz == 2'h2, isz == 2'h2};
    {rom, r80, r16, bus, ext, blk} = '0;
    off = {8'h0, a[19:0]};
    slot = a[19:14];
    lst[0] = FIXED_BLOCK;
    n = 1;
    for (int b = 3; b >= 0; b--)
      if (!cl[b])
      begin
        lst[n] = 3'(b);
        n++;
      end
    if (a[31:28] != 4'h0 && a[31:28] < 4'ha)
    begin
      ext[a[31:28] - 4'h1] = 1'b1;
      off = a[27:0];
    end
    else if (a[31:28] == 4'h0)
      case (a[27:20])
        8'h00: if (rmp && cpu) bus = 1'b1;
               else if (boot) rom = 1'b1;
               else ext[0] = 1'b1;
        8'h01: begin
          r80 = (slot == 0 && cl[1]) || (slot == 1 && cl[0]);
          blk = slot == 0 ? 3'h1 : 3'h0;
        end
        8'h02: begin
          r80 = (slot == 0 && cl[3]) || (slot == 1 && cl[2]);
          blk = slot == 0 ? 3'h3 : 3'h2;
        end
        8'h03: bus = 1'b1;
        8'h04: rom = 1'b1;
        8'h05: r16 = slot == 0;
        default: ;
      endcase
    if (bus && slot < n)
    begin
      r80 = 1'b1;
      blk = lst[slot[2:0]];
    end
    if (r80 || r16) off = {14'h0, a[13:0]};
    if (!r80) blk = 3'h0;
    err = !(rom || r80 || r16 || (|ext));
    if (err) off = 28'h0;
    return {1'b1, err, rom, r80, r16, ext, blk, off};
  endfunction

  ////////////////////////////////////////
  task automatic check(input string what, input logic [44:0] seen, input logic [44:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    if (fails == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic send(input logic [31:0] a, input logic c);
    @(posedge clk_sys_in);
    go <= 1'b1;
    go_addr <= a;
    go_cpu <= c;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_in) go <= 1'b0;
  endtask

  task automatic set_sizes(input logic [1:0] i, input logic [1:0] d);
    @(posedge clk_sys_in);
    go <= 1'b0;
    icoupled_size_in <= i;
    dcoupled_size_in <= d;
  endtask

  // Every size code pair, including the illegal code 3, over every internal-bank window
  task automatic sweep(input logic c);
    for (int i = 0; i < 16; i++)
    begin
      set_sizes(i[3:2], i[1:0]);
      foreach (bases[k])
      begin
        rnd = xs(rnd);
        send(bases[k] | {18'h0, rnd[13:0]}, c ^ rnd[20]);
      end
    end
  endtask

  // Mostly internal bank, slot field reaching past the last block
  task automatic rand_run(input int n);
    repeat (n)
    begin
      rnd = xs(rnd);
      if (rnd[9:7] == 3'h0) set_sizes(rnd[3:2], rnd[5:4]);
      send({rnd[8] ? rnd[31:28] : 4'h0, 5'h0, rnd[22:20], 3'h0, rnd[16:0]}, rnd[6]);
    end
  endtask

  ////////////////////////////////////////
  // Monitor: expectation taken at the request edge, answer one cycle later
  always @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      {mdl_remap, mdl_boot, latched, pend} = 4'h0;
      expq.delete();
    end
    else
    begin
      check("valid", resp_valid_out, pend);
      if (resp_valid_out === 1'b1 && expq.size() > 0)
        check("resp", {resp_valid_out, resp_error_out, sel_rom_out, sel_ram80_out,
          sel_ram16_out, ext_cs_out, sel_ram80_out ? ram_block_out : 3'h0,
          resp_error_out ? 28'h0 : mem_offset_out}, expq.pop_front());
      check("remap", remap_active_out, mdl_remap);
      check("slow", boot_slow_clock_out, !mdl_remap);
      check("boot", boot_from_rom_out, mdl_boot);
      check("static", {static_byte_select_out, static_bus16_out, static_cs_strobes_out},
        3'h7);
      pend = req_valid_in;
      if (req_valid_in === 1'b1)
        expq.push_back(expect_resp(req_addr_in, req_cpu_master_in, icoupled_size_in,
          dcoupled_size_in, mdl_remap, mdl_boot));
      if (!latched) mdl_boot = boot_mode_pin_in;
      latched = 1'b1;
      if (remap_set_in === 1'b1) mdl_remap = 1'b1;
    end
  end

  // Hang guard, well above the expected run length
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fails++;
      final_report;
    end
  end

  ////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    idle(2);
    sweep(1'b1);
    for (int b = 0; b < 16; b++)
    begin
      rnd = xs(rnd);
      send({b[3:0], rnd[27:0]}, rnd[31]);
    end
    rand_run(300);
    idle(2);
    // Boot software has retimed clocks and chip select zero before it remaps
    @(posedge clk_sys_in) remap_go <= 1'b1;
    @(posedge clk_sys_in) remap_go <= 1'b0;
    idle(2);
    sweep(1'b1);
    rand_run(200);
    idle(3);
    rst_b_in <= 1'b0;
    boot_mode_pin_in <= 1'b0;
    idle(3);
    rst_b_in <= 1'b1;
    idle(2);
    sweep(1'b1);
    idle(4);
    final_report;
  end
endmodule
